// [pc_cache_defs.vh]
// Constants shared by the program cache controller.
// Assumes inclusion by bare name from the design file.
`ifndef PC_CACHE_DEFS_VH
`define PC_CACHE_DEFS_VH

// Geometry
`define PC_ADDR_W      32
`define PC_TAG_W       25
`define PC_TAG_LSB     7
`define PC_WORD_W      7
`define PC_NSEC        8
`define PC_SEC_W       3
`define PC_IDX_W       10
`define PC_RAM_WORDS   1024
`define PC_RAM_LIMIT   32'h00000400
`define PC_BOOT_LIMIT  32'h00000040
`define PC_BOOT_AW     6
`define PC_LRU_OLDEST  3'h7

// Mode register fields
`define PC_MODE_CE     4
`define PC_MODE_BOOT   2:0
`define PC_MODE_RST    8'h00
`define PC_CE_DELAY    2'h3
`define PC_STRAP_WAIT  2'h2

// Execute-stage operation codes
`define PC_OP_LOCK     3'h1
`define PC_OP_UNLOCK   3'h2
`define PC_OP_FREE     3'h3
`define PC_OP_FLUSH    3'h4

// Post-flush word handling
`define PC_SKIP_FILL   2'h2
`define PC_SKIP_BYPASS 2'h1

// Register byte offsets
`define PC_REG_MODE    8'h00
`define PC_REG_PORT    8'h04
`define PC_REG_STATUS  8'h08
`define PC_REG_VSEL    8'h0C
`define PC_REG_VDATA   8'h10
`define PC_REG_LRU     8'h14
`define PC_REG_TAG     8'h20
`define PC_REG_TAGMASK 8'hE0

// Fetch states
`define PC_ST_IDLE     2'h0
`define PC_ST_LOOK     2'h1
`define PC_ST_EXT      2'h2

`endif

// [pc_cache.v]
// Program memory controller: internal program RAM or 8-sector instruction cache.
// Assumes fetch, decode, DMA and external memory logic on pclk; mode pins asynchronous.
//
// How it works
// RULE_01 - Cache enable change reaches fetches after three decode cycles.
// RULE_02 - Software changes boot mode bits separately from cache enable.
// RULE_03 - Lock or unlock within three cycles of enabling cache traps.
// RULE_04 - First word after flush is filled then left invalid.
// RULE_05 - Second word after flush bypasses cache without touching any state.
// RULE_06 - Boot map in cache mode: hits from boot ROM, misses external.
// RULE_07 - Software leaves cache mode and flushes before mapping boot ROM.
// RULE_08 - Port select redirects external fetches; cache contents stay as they are.
// RULE_09 - Conditional jump fetches both sequential and target word first.
// RULE_10 - Either speculative fetch may miss and evict the LRU sector.
// RULE_11 - After reset plain RAM mode, mode bits taken from mode pins.
// RULE_12 - DMA writes in RAM mode set the written word's valid bit.
// RULE_13 - Lock acts on the aligned 128-word sector holding the address.
// RULE_14 - Eight sectors, each locked independently in any mix.
// RULE_15 - Valid words in locked sectors hit without a miss.
// RULE_16 - Newly locked sector fills by individual word misses.
// RULE_17 - Unlock clears lock of the sector holding the address.
// RULE_18 - Free-all clears every sector lock at once.
// RULE_19 - Tags, valid bits, locks and next victim always readable.
// RULE_20 - Instruction acts in the mode in force at its execution.
// RULE_21 - Software waits three cycles after enabling cache before locking.
// RULE_22 - Sector miss replaces oldest unlocked sector; locked ones still age.
// RULE_23 - Reset clears valid and locks, tags 0..7, sector 0 newest.
// RULE_24 - In cache mode DMA strobes to program memory are blocked.
// RULE_25 - Tag is address above low seven bits; hit needs valid word.
`timescale 1ns/100ps
`include "pc_cache_defs.vh"

module pc_cache (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Mode strap pins
  input  wire [2:0]  mode_pins,
  // Instruction fetch
  input  wire        fetch_req,
  input  wire [31:0] fetch_addr,
  input  wire        fetch_jcc,
  input  wire [31:0] fetch_tgt,
  output wire        fetch_ready,
  output reg         fetch_valid,
  output reg  [31:0] fetch_data,
  output reg  [31:0] fetch_tgt_data,
  // Execute stage
  input  wire        instr_valid,
  input  wire [2:0]  instr_op,
  input  wire [31:0] instr_ea,
  output reg         illegal_trap,
  // External program memory
  output reg         ext_req,
  output reg  [31:0] ext_addr,
  output reg         ext_port,
  input  wire        ext_ack,
  input  wire [31:0] ext_rdata,
  // Boot ROM
  output wire [5:0]  boot_rom_addr,
  input  wire [31:0] boot_rom_data,
  // DMA to program memory
  input  wire        dma_wr_stb,
  input  wire        dma_rd_stb,
  input  wire [31:0] dma_addr,
  input  wire [31:0] dma_wdata,
  output reg  [31:0] dma_rdata,
  output wire        dma_ext_wr_stb,
  output wire        dma_ext_rd_stb
);

  // Storage
  reg [31:0]            ram_q [0:`PC_RAM_WORDS-1];
  reg [`PC_RAM_WORDS-1:0] valid_q;
  reg [`PC_TAG_W-1:0]   tag_q [0:`PC_NSEC-1];
  reg [`PC_SEC_W-1:0]   age_q [0:`PC_NSEC-1];
  reg [`PC_NSEC-1:0]    lock_q;

  // Control state
  reg [7:0]  mode_q;
  reg        ce_eff_q;
  reg [1:0]  ce_cnt_q;
  reg        port_q;
  reg [4:0]  vsel_q;
  reg [2:0]  pins_s1_q;
  reg [2:0]  pins_s2_q;
  reg [1:0]  strap_cnt_q;
  reg        strap_done_q;
  reg [1:0]  state_q;
  reg [31:0] cur_q;
  reg [31:0] tgt_q;
  reg        jcc_q;
  reg        second_q;
  reg [31:0] data0_q;
  reg        fill_q;
  reg        setv_q;
  reg [`PC_IDX_W-1:0] fidx_q;
  reg [1:0]  skip_q;

  integer i;
  integer j;

  // Lookup address is the jump target once the sequential word is done
  wire [31:0] la = second_q ? tgt_q : cur_q;
  wire [`PC_NSEC-1:0] hit_f;
  wire [`PC_NSEC-1:0] hit_i;

  genvar g;
  generate
    for (g = 0; g < `PC_NSEC; g = g + 1) begin : g_tag
      assign hit_f[g] = (tag_q[g] == la[31:`PC_TAG_LSB]);       // RULE_25
      assign hit_i[g] = (tag_q[g] == instr_ea[31:`PC_TAG_LSB]); // RULE_13
    end
  endgenerate

  // Encoders and victim choice
  reg [`PC_SEC_W-1:0] hsec;
  reg [`PC_SEC_W-1:0] isec;
  reg [`PC_SEC_W-1:0] vsec;
  reg                 vic_ok;
  always @* begin
    hsec = {`PC_SEC_W{1'b0}};
    isec = {`PC_SEC_W{1'b0}};
    vsec = {`PC_SEC_W{1'b0}};
    vic_ok = 1'b0;
    for (i = 0; i < `PC_NSEC; i = i + 1) begin
      if (hit_f[i])
        hsec = i[`PC_SEC_W-1:0];
      if (hit_i[i])
        isec = i[`PC_SEC_W-1:0];
      // Oldest unlocked sector; locked ones keep ageing but are skipped
      if (!lock_q[i] && (!vic_ok || age_q[i] > age_q[vsec])) begin // RULE_22
        vsec = i[`PC_SEC_W-1:0];
        vic_ok = 1'b1;
      end
    end
  end

  wire sec_hit  = |hit_f;
  wire [`PC_IDX_W-1:0] hidx = {hsec, la[`PC_WORD_W-1:0]};
  wire [`PC_IDX_W-1:0] vidx = {vsec, la[`PC_WORD_W-1:0]};
  wire word_ok  = sec_hit & valid_q[hidx];
  wire in_boot  = (mode_q[`PC_MODE_BOOT] != 3'h0) && (la < `PC_BOOT_LIMIT);
  wire in_ram   = (la < `PC_RAM_LIMIT);
  assign boot_rom_addr = la[`PC_BOOT_AW-1:0];

  // Lookup outcome for the current word
  reg        l_int;
  reg [31:0] l_data;
  reg        l_fill;
  reg        l_repl;
  reg        l_touch;
  reg [`PC_IDX_W-1:0] l_idx;
  always @* begin
    l_int = 1'b0;
    l_data = 32'h00000000;
    l_fill = 1'b0;
    l_repl = 1'b0;
    l_touch = 1'b0;
    l_idx = hidx;
    if (!ce_eff_q) begin
      // Plain RAM mode: no cache state moves
      l_int = in_boot | in_ram;
      l_data = in_boot ? boot_rom_data : ram_q[la[`PC_IDX_W-1:0]];
    end else if (skip_q == `PC_SKIP_BYPASS) begin
      l_int = 1'b0;                                  // RULE_05
    end else if (word_ok) begin
      l_int = 1'b1;                                  // RULE_15
      l_data = in_boot ? boot_rom_data : ram_q[hidx]; // RULE_06
      l_touch = 1'b1;
    end else if (sec_hit) begin
      l_fill = 1'b1;                                 // RULE_16
      l_touch = 1'b1;
    end else if (vic_ok) begin
      // Speculative jump words evict just like real ones
      l_fill = 1'b1;                                 // RULE_10
      l_repl = 1'b1;
      l_touch = 1'b1;
      l_idx = vidx;
    end
  end

  // Execute-stage operations, judged in the mode in force now
  wire op_lk   = instr_valid && (instr_op == `PC_OP_LOCK || instr_op == `PC_OP_UNLOCK);
  wire trap_d  = op_lk && mode_q[`PC_MODE_CE] && (ce_cnt_q != 2'h0); // RULE_03
  wire op_go   = op_lk && !trap_d;
  wire op_new  = op_go && (instr_op == `PC_OP_LOCK) && !(|hit_i) && vic_ok;
  wire [`PC_SEC_W-1:0] op_sec = op_new ? vsec : isec;
  wire op_sel  = (|hit_i) || op_new;
  wire op_flush = instr_valid && (instr_op == `PC_OP_FLUSH);

  // One LRU touch per cycle; an executing lock or unlock takes precedence
  wire look_touch = (state_q == `PC_ST_LOOK) && l_touch;
  wire touch_en  = (op_go && op_sel && ce_eff_q) || look_touch;
  wire [`PC_SEC_W-1:0] touch_sec = (op_go && op_sel && ce_eff_q) ? op_sec :
                                   (l_repl ? vsec : hsec);

  wire word_done = ((state_q == `PC_ST_LOOK) && l_int) || ((state_q == `PC_ST_EXT) && ext_ack);
  wire [31:0] word_data = (state_q == `PC_ST_EXT) ? ext_rdata : l_data;
  wire ram_dma = (dma_addr < `PC_RAM_LIMIT);

  assign fetch_ready = (state_q == `PC_ST_IDLE);
  // Program memory DMA is dead while the cache owns the DMA slot
  assign dma_ext_wr_stb = dma_wr_stb & ~ce_eff_q & ~ram_dma; // RULE_24
  assign dma_ext_rd_stb = dma_rd_stb & ~ce_eff_q & ~ram_dma; // RULE_24
  assign pready = 1'b1;

  // Pin synchroniser; only the second stage is looked at
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_q <= 3'h0;
      pins_s2_q <= 3'h0;
    end else begin
      pins_s1_q <= mode_pins;
      pins_s2_q <= pins_s1_q;
    end
  end

  // Mode register, delayed cache enable, port select, strap capture
  wire apb_wr = psel & penable & pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `PC_MODE_RST;
      ce_eff_q <= 1'b0;                             // RULE_11
      ce_cnt_q <= 2'h0;
      port_q <= 1'b0;
      vsel_q <= 5'h00;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      illegal_trap <= 1'b0;
    end else begin
      illegal_trap <= trap_d;
      if (!strap_done_q) begin
        // Wait for the synchroniser to settle before latching the pins
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_cnt_q == `PC_STRAP_WAIT) begin
          mode_q[`PC_MODE_BOOT] <= pins_s2_q;        // RULE_11
          strap_done_q <= 1'b1;
        end
      end
      if (instr_valid && ce_cnt_q != 2'h0) begin
        ce_cnt_q <= ce_cnt_q - 2'h1;
        if (ce_cnt_q == 2'h1)
          ce_eff_q <= mode_q[`PC_MODE_CE];           // RULE_01
      end
      if (apb_wr && paddr == `PC_REG_MODE) begin
        mode_q <= pwdata[7:0];
        if (pwdata[`PC_MODE_CE] != mode_q[`PC_MODE_CE])
          ce_cnt_q <= `PC_CE_DELAY;                  // RULE_01
      end
      if (apb_wr && paddr == `PC_REG_PORT)
        port_q <= pwdata[0];                         // RULE_08
      if (apb_wr && paddr == `PC_REG_VSEL)
        vsel_q <= pwdata[4:0];
    end
  end

  // Fetch engine and all cache state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= `PC_ST_IDLE;
      valid_q <= {`PC_RAM_WORDS{1'b0}};              // RULE_23
      lock_q <= {`PC_NSEC{1'b0}};                    // RULE_23
      for (i = 0; i < `PC_NSEC; i = i + 1) begin
        tag_q[i] <= i[`PC_TAG_W-1:0];                // RULE_23
        age_q[i] <= i[`PC_SEC_W-1:0];                // RULE_23
      end
      cur_q <= 32'h00000000;
      tgt_q <= 32'h00000000;
      jcc_q <= 1'b0;
      second_q <= 1'b0;
      data0_q <= 32'h00000000;
      fill_q <= 1'b0;
      setv_q <= 1'b0;
      fidx_q <= {`PC_IDX_W{1'b0}};
      skip_q <= 2'h0;
      fetch_valid <= 1'b0;
      fetch_data <= 32'h00000000;
      fetch_tgt_data <= 32'h00000000;
      ext_req <= 1'b0;
      ext_addr <= 32'h00000000;
      ext_port <= 1'b0;
      dma_rdata <= 32'h00000000;
    end else begin
      fetch_valid <= 1'b0;
      ext_port <= port_q;                            // RULE_08
      // LRU stack: touched sector becomes newest, younger ones age by one
      if (touch_en) begin
        for (i = 0; i < `PC_NSEC; i = i + 1) begin
          if (i[`PC_SEC_W-1:0] == touch_sec)
            age_q[i] <= 3'h0;
          else if (age_q[i] < age_q[touch_sec])
            age_q[i] <= age_q[i] + 3'h1;
        end
      end
      case (state_q)
        `PC_ST_IDLE: begin
          if (fetch_req) begin
            cur_q <= fetch_addr;
            tgt_q <= fetch_tgt;
            jcc_q <= fetch_jcc;                      // RULE_09
            second_q <= 1'b0;
            state_q <= `PC_ST_LOOK;
          end
        end
        `PC_ST_LOOK: begin
          if (ce_eff_q && skip_q != 2'h0)
            skip_q <= skip_q - 2'h1;
          if (l_repl) begin
            tag_q[vsec] <= la[31:`PC_TAG_LSB];
            for (j = 0; j < (1 << `PC_WORD_W); j = j + 1)
              valid_q[{vsec, j[`PC_WORD_W-1:0]}] <= 1'b0;
          end
          if (!l_int) begin
            ext_req <= 1'b1;
            ext_addr <= la;
            fill_q <= l_fill;
            // First word after a flush is written but never marked valid
            setv_q <= (skip_q != `PC_SKIP_FILL);     // RULE_04
            fidx_q <= l_idx;
            state_q <= `PC_ST_EXT;
          end
        end
        `PC_ST_EXT: begin
          if (ext_ack) begin
            ext_req <= 1'b0;
            if (fill_q) begin
              ram_q[fidx_q] <= ext_rdata;
              if (setv_q)
                valid_q[fidx_q] <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= `PC_ST_IDLE;
        end
      endcase
      // Word complete: either hold it for the target or hand it back, together with the held word for a jump
      if (word_done) begin
        if (jcc_q && !second_q) begin
          data0_q <= word_data;                      // RULE_09
          second_q <= 1'b1;
          state_q <= `PC_ST_LOOK;
        end else begin
          fetch_valid <= 1'b1;
          fetch_data <= jcc_q ? data0_q : word_data;
          fetch_tgt_data <= jcc_q ? word_data : 32'h00000000;
          state_q <= `PC_ST_IDLE;
        end
      end
      // DMA into internal RAM only while cache is off
      if (dma_wr_stb && !ce_eff_q && ram_dma) begin
        ram_q[dma_addr[`PC_IDX_W-1:0]] <= dma_wdata;
        valid_q[dma_addr[`PC_IDX_W-1:0]] <= 1'b1;    // RULE_12
      end
      if (dma_rd_stb && !ce_eff_q && ram_dma)
        dma_rdata <= ram_q[dma_addr[`PC_IDX_W-1:0]];
      // Sector operations act in the mode at execution time
      if (op_go && op_sel) begin
        if (instr_op == `PC_OP_LOCK) begin
          lock_q[op_sec] <= 1'b1;                    // RULE_13 RULE_14
          if (op_new) begin
            tag_q[vsec] <= instr_ea[31:`PC_TAG_LSB]; // RULE_16
            for (j = 0; j < (1 << `PC_WORD_W); j = j + 1)
              valid_q[{vsec, j[`PC_WORD_W-1:0]}] <= 1'b0;
          end
        end else begin
          lock_q[op_sec] <= 1'b0;                    // RULE_17
        end
      end
      if (instr_valid && instr_op == `PC_OP_FREE)
        lock_q <= {`PC_NSEC{1'b0}};                  // RULE_18
      // Flush restores the reset mapping; locks are left to free-all
      if (op_flush) begin
        valid_q <= {`PC_RAM_WORDS{1'b0}};
        for (i = 0; i < `PC_NSEC; i = i + 1) begin
          tag_q[i] <= i[`PC_TAG_W-1:0];
          age_q[i] <= i[`PC_SEC_W-1:0];
        end
        skip_q <= ce_eff_q ? `PC_SKIP_FILL : 2'h0;   // RULE_04 RULE_20
      end
    end
  end

  // Register read mux, captured in the setup phase
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if ((paddr & `PC_REG_TAGMASK) == `PC_REG_TAG)
      rd_d[`PC_TAG_W-1:0] = tag_q[paddr[4:2]];       // RULE_19
    else begin
      case (paddr)
        `PC_REG_MODE:   rd_d[7:0] = mode_q;
        `PC_REG_PORT:   rd_d[0] = port_q;
        `PC_REG_STATUS: begin
          rd_d[0] = ce_eff_q;
          rd_d[1] = (ce_cnt_q != 2'h0);
          rd_d[2] = (state_q != `PC_ST_IDLE);
          rd_d[3] = (skip_q != 2'h0);
          rd_d[15:8] = lock_q;                       // RULE_19
          if (vic_ok)
            rd_d[16 + vsec] = 1'b1;                  // RULE_19
        end
        `PC_REG_VSEL:   rd_d[4:0] = vsel_q;
        `PC_REG_VDATA:  rd_d = valid_q[vsel_q * 32 +: 32]; // RULE_19
        `PC_REG_LRU: begin
          for (i = 0; i < `PC_NSEC; i = i + 1)
            rd_d[i * 3 +: 3] = age_q[i];
        end
        default:        err_d = 1'b1;
      endcase
    end
  end

  // APB read data and error stand through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= err_d;
    end
  end

endmodule // pc_cache

// [pcm_cache_sva.sv]
// Port-level checks for the program cache controller.
// Assumes the bind below; sees only the pc_cache ports.
`timescale 1ns/100ps
`include "pc_cache_defs.vh"
module pcm_cache_sva (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Fetch
  input wire        fetch_req,
  input wire        fetch_jcc,
  input wire        fetch_ready,
  input wire        fetch_valid,
  // Execute
  input wire        instr_valid,
  input wire [2:0]  instr_op,
  input wire        illegal_trap,
  // External memory
  input wire        ext_req,
  input wire [31:0] ext_addr,
  input wire        ext_ack,
  // DMA
  input wire        dma_wr_stb,
  input wire        dma_rd_stb,
  input wire [31:0] dma_addr,
  input wire        dma_ext_wr_stb,
  input wire        dma_ext_rd_stb
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A plain fetch is answered or sent outside within a bounded time
  sequence s_take;
    fetch_req && fetch_ready && !fetch_jcc;
  endsequence
  sequence s_answer;
    ##[2:3] (fetch_valid || ext_req);
  endsequence
  property p_fetch_lat;
    s_take |-> s_answer;
  endproperty
  a_fetch_lat: assert property (p_fetch_lat) else $error("fetch not answered");
  property p_busy;
    fetch_req && fetch_ready |=> !fetch_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("fetch engine not busy");
  property p_ready_at_valid;
    fetch_valid |-> fetch_ready;
  endproperty
  a_ready_at_valid: assert property (p_ready_at_valid) else $error("not ready at answer");
  // Miss request held steady until answered, then dropped
  property p_ext_hold;
    ext_req && !ext_ack |=> ext_req && $stable(ext_addr);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("miss request moved");
  property p_ext_drop;
    ext_req && ext_ack |=> !ext_req;
  endproperty
  a_ext_drop: assert property (p_ext_drop) else $error("miss request not dropped");
  // Trap only follows a lock or unlock
  property p_trap_cause;
    illegal_trap |-> $past(instr_valid)
      && ($past(instr_op) == `PC_OP_LOCK || $past(instr_op) == `PC_OP_UNLOCK);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without cause");
  // DMA strobes reach outside only for their own high addresses
  property p_dma_wr;
    dma_ext_wr_stb |-> dma_wr_stb && dma_addr >= 32'h00000400;
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("stray dma write strobe");
  property p_dma_rd;
    dma_ext_rd_stb |-> dma_rd_stb && dma_addr >= 32'h00000400;
  endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("stray dma read strobe");
  property p_unmapped;
    psel && !penable && (paddr == 8'h18 || paddr == 8'h1C) |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
endmodule // pcm_cache_sva

bind pc_cache pcm_cache_sva u_sva (.*);

// [pcm_ext_mem.sv]
// External program memory model answering cache miss requests.
// Assumes one request held on ext_req until a one-cycle ext_ack.
`timescale 1ns/100ps
module pcm_ext_mem (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Request
  input  wire        ext_req,
  input  wire [31:0] ext_addr,
  input  wire        ext_port,
  // Answer
  output reg         ext_ack,
  output reg  [31:0] ext_rdata,
  output reg  [31:0] n_acks
);
  reg [1:0] wait_q;
  // Delay of 0..3 cycles varies per request; data toggles when not valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ack   <= 1'b0;
      ext_rdata <= 32'h0;
      n_acks    <= 32'h0;
      wait_q    <= 2'h0;
    end else if (ext_ack) begin
      ext_ack   <= 1'b0;
      ext_rdata <= ~ext_rdata;
      wait_q    <= n_acks[1:0];
    end else if (ext_req && wait_q == 2'h0) begin
      ext_ack   <= 1'b1;
      ext_rdata <= ext_addr ^ {ext_port, 31'h0} ^ 32'h3C3C0000;
      n_acks    <= n_acks + 32'h1;
    end else begin
      wait_q    <= (ext_req) ? wait_q - 2'h1 : wait_q;
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule // pcm_ext_mem

// [test_program_cache_mode_control.sv]
// Self-checking bench for the program cache controller.
// Assumes pc_cache, its checker and the memory model compile first.
`timescale 1ns/100ps
`include "pc_cache_defs.vh"
module test_program_cache_mode_control;
  reg        pclk, presetn, psel, penable, pwrite, fetch_req, fetch_jcc;
  reg        instr_valid, dma_wr_stb, dma_rd_stb, err;
  reg [7:0]  paddr;
  reg [2:0]  mode_pins, instr_op;
  reg [31:0] pwdata, fetch_addr, fetch_tgt, instr_ea, dma_addr, dma_wdata;
  reg [31:0] rd, got_d, got_t, acks0, lru_e, ra, seed, rnd;
  reg [31:0] w [0:3];
  wire        pready, pslverr, fetch_ready, fetch_valid, illegal_trap, ext_req, ext_port;
  wire        ext_ack, dma_ext_wr_stb, dma_ext_rd_stb;
  wire [31:0] prdata, fetch_data, fetch_tgt_data, ext_addr, ext_rdata, dma_rdata, n_acks;
  wire [5:0]  boot_rom_addr;
  wire [31:0] boot_rom_data;
  int         miscompares, samples_checked;
  integer     i;

  // Boot ROM contents are a simple address pattern
  assign boot_rom_data = {26'h0, boot_rom_addr} ^ 32'hB00B0000;

  pc_cache u_dut (.*);
  pcm_ext_mem u_mem (
    .pclk(pclk), .presetn(presetn), .ext_req(ext_req), .ext_addr(ext_addr),
    .ext_port(ext_port), .ext_ack(ext_ack), .ext_rdata(ext_rdata), .n_acks(n_acks)
  );

  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function [31:0] exp_ext(input [31:0] a, input p);
    exp_ext = a ^ {p, 31'h0} ^ 32'h3C3C0000;
  endfunction

  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        $display("Error at %0t got %h expected %h", $time, got, exp);
        miscompares++;
      end
    end
  endtask

  // APB transfer
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k = k + 1; end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin miscompares++; close_out; end
    end
  endtask

  // Bounded fetch
  task fetch(input [31:0] a, input j, input [31:0] t);
    integer k;
    begin
      acks0 = n_acks;
      @(posedge pclk);
      fetch_req <= 1'b1; fetch_addr <= a; fetch_jcc <= j; fetch_tgt <= t;
      @(posedge pclk);
      fetch_req <= 1'b0;
      for (k = 0; k < 60; k = k + 1) begin
        @(posedge pclk);
        #1;
        if (fetch_valid === 1'b1) break;
      end
      if (fetch_valid !== 1'b1) begin miscompares++; close_out; end
      got_d = fetch_data;
      got_t = fetch_tgt_data;
    end
  endtask

  task instr(input [2:0] op, input [31:0] ea, input tr);
    begin
      @(posedge pclk);
      instr_valid <= 1'b1; instr_op <= op; instr_ea <= ea;
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
      chk({31'h0, illegal_trap}, {31'h0, tr});
    end
  endtask

  task dma(input wr, input [31:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      dma_wr_stb <= wr; dma_rd_stb <= !wr; dma_addr <= a; dma_wdata <= d;
      #1;
      chk({31'h0, wr ? dma_ext_wr_stb : dma_ext_rd_stb}, {31'h0, a >= 32'h400});
      @(posedge pclk);
      dma_wr_stb <= 1'b0;
      dma_rd_stb <= 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, fetch_req, fetch_jcc, instr_valid, dma_wr_stb, dma_rd_stb} = 8'h00;
    {paddr, instr_op} = 11'h000;
    {pwdata, fetch_addr, fetch_tgt, instr_ea, dma_addr, dma_wdata} = 192'h0;
    seed = $urandom(32'h551F);
    rnd = $urandom_range(7, 1);
    mode_pins = rnd[2:0];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `PC_REG_MODE, 32'h0);
    chk(rd, {29'h0, mode_pins});
    apb(1'b1, `PC_REG_MODE, 32'h0);
    lru_e = 32'h0;
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b0, {3'h1, i[2:0], 2'h0}, 32'h0);
      chk(rd, i);
      lru_e = lru_e | (i << (3 * i));
    end
    apb(1'b0, `PC_REG_LRU, 32'h0);
    chk(rd, lru_e);
    apb(1'b0, `PC_REG_STATUS, 32'h0);
    chk(rd, 32'h00800000);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      w[i] = $urandom;
      dma(1'b1, i, w[i]);
    end
    dma(1'b1, 32'h800, 32'h0);
    dma(1'b0, 32'h801, 32'h0);
    dma(1'b0, 32'h1, 32'h0);
    #1 chk(dma_rdata, w[1]);
    apb(1'b0, `PC_REG_VDATA, 32'h0);
    chk(rd, 32'hF);
    fetch(32'h2, 1'b0, 32'h0);
    chk(got_d, w[2]);
    chk(n_acks, acks0);
    $display("test ram mode done");
    apb(1'b1, `PC_REG_MODE, 32'h10);
    instr(`PC_OP_LOCK, 32'h0, 1'b1);
    instr(3'h0, 32'h0, 1'b0);
    apb(1'b0, `PC_REG_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    instr(3'h0, 32'h0, 1'b0);
    instr(`PC_OP_LOCK, 32'h0, 1'b0);
    instr(`PC_OP_LOCK, 32'd200, 1'b0);
    apb(1'b0, `PC_REG_STATUS, 32'h0);
    chk({16'h0, rd[23:8]}, 32'h8003);
    chk({31'h0, rd[0]}, 32'h1);
    fetch(32'h3, 1'b0, 32'h0);
    chk(got_d, w[3]);
    chk(n_acks, acks0);
    fetch(32'd160, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd160, 1'b0));
    chk(n_acks, acks0 + 32'h1);
    ra = $urandom | 32'h400;
    fetch(ra, 1'b0, 32'h0);
    chk(got_d, exp_ext(ra, 1'b0));
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, {7'h0, ra[31:7]});
    instr(`PC_OP_UNLOCK, 32'd140, 1'b0);
    apb(1'b0, `PC_REG_STATUS, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h1);
    instr(`PC_OP_LOCK, 32'd400, 1'b0);
    instr(`PC_OP_FREE, 32'h0, 1'b0);
    apb(1'b0, `PC_REG_STATUS, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h0);
    $display("test locking done");
    instr(`PC_OP_FLUSH, 32'h0, 1'b0);
    fetch(32'd10, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd10, 1'b0));
    fetch(32'd3000, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd3000, 1'b0));
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, `PC_REG_VDATA, 32'h0);
    chk(rd, 32'h0);
    fetch(32'd3000, 1'b0, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'd23);
    fetch(32'd12, 1'b1, 32'd4100);
    chk(got_d, exp_ext(32'd12, 1'b0));
    chk(got_t, exp_ext(32'd4100, 1'b0));
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'd32);
    $display("test flush and jump done");
    apb(1'b1, `PC_REG_PORT, 32'h1);
    fetch(32'd5000, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd5000, 1'b1));
    fetch(32'd12, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd12, 1'b0));
    apb(1'b1, `PC_REG_MODE, 32'h11);
    fetch(32'd12, 1'b0, 32'h0);
    chk(got_d, 32'hB00B000C);
    fetch(32'd20, 1'b0, 32'h0);
    chk(got_d, exp_ext(32'd20, 1'b1));
    apb(1'b1, `PC_REG_MODE, 32'h10);
    apb(1'b1, `PC_REG_MODE, 32'h0);
    repeat (3) instr(3'h0, 32'h0, 1'b0);
    instr(`PC_OP_FLUSH, 32'h0, 1'b0);
    apb(1'b1, `PC_REG_MODE, 32'h1);
    fetch(32'd12, 1'b0, 32'h0);
    chk(got_d, 32'hB00B000C);
    $display("test port and boot done");
    close_out;
  end
endmodule // test_program_cache_mode_control
